// *** logic/clock_gen_lock_status.v ***
// Overview of operation
// - Set sticky loss-of-lock flag after lock lost
// - Loss-of-lock interrupt when enable set or its event unmasked
// - Reset or write one clears flag
// - Bit 6 shows lock; no detection loops off
// - Setting changes clear lock until reacquired
// - Stop mode clears lock until exit
// - Low-power bypass clears lock until exit
// - Bit 5 shows synchronized loop source
// - Bit 4 shows synchronized reference source
// - Bits 3:2 show synchronized clock mode
//
// Chosen here: the register addresses and the Wishbone interface to the registers.
`include "clock_gen_lock_status_map.vh"

module clock_gen_lock_status #(
  parameter SYNC_STAGES = `SYNC_STAGES
) (
  // Clock and reset.
  input wire i_clock,
  input wire i_rst,
  // Wishbone classic slave.
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [3:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  // Clock generator configuration and raw state.
  input wire i_fll_enabled,
  input wire i_pll_enabled,
  input wire i_loop_in_tolerance,
  input wire i_ref_source_select,
  input wire i_pll_select,
  input wire [1:0] i_clock_select,
  input wire [2:0] i_ref_divider,
  input wire [7:0] i_internal_ref_adjust,
  input wire [3:0] i_vco_divider,
  input wire [2:0] i_op_mode,
  input wire i_stop_mode,
  // Interrupt and status outputs.
  output reg o_irq,
  output reg o_lock
);

  // --------------------------------------------------------------------
  // Synchronizers for the selections coming from the generator domain.
  // --------------------------------------------------------------------
  reg [SYNC_STAGES-1:0] sync_pll;
  reg [SYNC_STAGES-1:0] sync_ref;
  reg [SYNC_STAGES-1:0] sync_mode_hi;
  reg [SYNC_STAGES-1:0] sync_mode_lo;
  wire pll_select_status;
  wire ref_source_status;
  wire [1:0] clock_mode_status;

  // Each status only follows its select after the full chain.
  always @(posedge i_clock) begin
    if (i_rst) begin
      sync_pll <= {SYNC_STAGES{1'b0}};
      sync_ref <= {SYNC_STAGES{1'b1}};
      sync_mode_hi <= {SYNC_STAGES{1'b0}};
      sync_mode_lo <= {SYNC_STAGES{1'b0}};
    end else begin
      sync_pll <= {sync_pll[SYNC_STAGES-2:0], i_pll_select};
      sync_ref <= {sync_ref[SYNC_STAGES-2:0], i_ref_source_select};
      sync_mode_hi <= {sync_mode_hi[SYNC_STAGES-2:0], i_clock_select[1]};
      sync_mode_lo <= {sync_mode_lo[SYNC_STAGES-2:0], i_clock_select[0]};
    end
  end

  assign pll_select_status = sync_pll[SYNC_STAGES-1];
  assign ref_source_status = sync_ref[SYNC_STAGES-1];
  // Mode bits are read together at the end of the chain.
  assign clock_mode_status = {sync_mode_hi[SYNC_STAGES-1],
                              sync_mode_lo[SYNC_STAGES-1]};

  // --------------------------------------------------------------------
  // Change detection on settings that invalidate lock.
  // --------------------------------------------------------------------
  reg prev_ref_select;
  reg prev_pll_select;
  reg [2:0] prev_ref_divider;
  reg [7:0] prev_adjust;
  reg [3:0] prev_vco_divider;
  reg prev_stop;
  reg prev_low_power;
  wire in_internal_fll;
  wire in_external_pll;
  wire in_low_power;
  wire detect_on;
  wire settings_changed;
  wire lock_kill;

  assign in_internal_fll = (i_op_mode == `OP_FLL_ENG_INT) ||
                           (i_op_mode == `OP_FLL_BYP_INT);
  assign in_external_pll = (i_op_mode == `OP_PLL_BYP_EXT) ||
                           (i_op_mode == `OP_PLL_ENG_EXT);
  assign in_low_power = (i_op_mode == `OP_LOW_POWER_INT) ||
                        (i_op_mode == `OP_LOW_POWER_EXT);
  // Both loops off means nothing to detect.
  assign detect_on = (i_fll_enabled | i_pll_enabled) & ~in_low_power;

  assign settings_changed =
    (i_ref_source_select != prev_ref_select) ||
    (i_pll_select != prev_pll_select) ||
    (i_ref_divider != prev_ref_divider) ||
    (in_internal_fll && (i_internal_ref_adjust != prev_adjust)) ||
    (in_external_pll && (i_vco_divider != prev_vco_divider));

  // Kill events: setting change, stop entry, low-power entry or held modes.
  assign lock_kill = settings_changed ||
                     (i_stop_mode && !prev_stop) || i_stop_mode ||
                     (in_low_power && !prev_low_power) ||
                     !detect_on;

  // Previous values are kept for edge and change detection.
  always @(posedge i_clock) begin
    if (i_rst) begin
      prev_ref_select <= 1'b1;
      prev_pll_select <= 1'b0;
      prev_ref_divider <= 3'h0;
      prev_adjust <= 8'h00;
      prev_vco_divider <= 4'h0;
      prev_stop <= 1'b0;
      prev_low_power <= 1'b0;
    end else begin
      prev_ref_select <= i_ref_source_select;
      prev_pll_select <= i_pll_select;
      prev_ref_divider <= i_ref_divider;
      prev_adjust <= i_internal_ref_adjust;
      prev_vco_divider <= i_vco_divider;
      prev_stop <= i_stop_mode;
      prev_low_power <= in_low_power;
    end
  end

  // --------------------------------------------------------------------
  // Lock indication and sticky loss-of-lock flag.
  // --------------------------------------------------------------------
  reg lock;
  reg ever_locked;
  reg loss_of_lock_flag;
  reg loss_of_lock_irq_enable;
  reg [1:0] irq_status;
  reg [1:0] irq_mask;
  wire lost_event;
  wire gained_event;
  wire bus_req;
  wire wr_lane0;
  wire [1:0] w1c_status;
  wire clear_lol;

  // A lock is lost only if it was held; a forced clear is not a drift.
  assign lost_event = lock && detect_on && !i_loop_in_tolerance &&
                      !settings_changed && !i_stop_mode;
  assign gained_event = !lock && !lock_kill && i_loop_in_tolerance;

  assign bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wr_lane0 = bus_req && i_wb_we && i_wb_sel[0];
  assign clear_lol = wr_lane0 && (i_wb_adr == `ADDR_STATUS_CONTROL) &&
                     i_wb_dat[`BIT_LOSS_OF_LOCK];
  assign w1c_status = (wr_lane0 && (i_wb_adr == `ADDR_IRQ_STATUS)) ?
                      i_wb_dat[1:0] : 2'h0;

  // Lock only rises after the loop is in tolerance with no kill pending.
  always @(posedge i_clock) begin
    if (i_rst) begin
      lock <= 1'b0;
      ever_locked <= 1'b0;
    end else begin
      if (lock_kill) begin
        lock <= 1'b0;
      end else if (i_loop_in_tolerance) begin
        lock <= 1'b1;
      end else begin
        lock <= 1'b0;
      end
      if (gained_event) begin
        ever_locked <= 1'b1;
      end
    end
  end

  // Set wins over a simultaneous write-one clear.
  always @(posedge i_clock) begin
    if (i_rst) begin
      loss_of_lock_flag <= 1'b0;
    end else if (lost_event && ever_locked) begin
      loss_of_lock_flag <= 1'b1;
    end else if (clear_lol && loss_of_lock_flag) begin
      loss_of_lock_flag <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Interrupt status, mask and output.
  // --------------------------------------------------------------------
  wire [1:0] irq_events;
  assign irq_events = {gained_event, lost_event && ever_locked};

  // Sticky bits; a new event beats a write-one clear in the same cycle.
  always @(posedge i_clock) begin
    if (i_rst) begin
      irq_status <= 2'h0;
    end else begin
      irq_status <= irq_events | (irq_status & ~w1c_status);
    end
  end

  // The flag request and the generic status request share one line.
  always @(posedge i_clock) begin
    if (i_rst) begin
      o_irq <= 1'b0;
      o_lock <= 1'b0;
    end else begin
      o_irq <= (loss_of_lock_flag && loss_of_lock_irq_enable) ||
               (|(irq_status & irq_mask));
      o_lock <= lock;
    end
  end

  // --------------------------------------------------------------------
  // Wishbone register access.
  // --------------------------------------------------------------------
  // Ack comes one cycle after the request and drops the cycle after.
  always @(posedge i_clock) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
      loss_of_lock_irq_enable <= 1'b0;
      irq_mask <= 2'h0;
    end else begin
      o_wb_ack <= bus_req;
      o_wb_dat <= 32'h00000000;
      if (wr_lane0 && (i_wb_adr == `ADDR_CONTROL)) begin
        loss_of_lock_irq_enable <= i_wb_dat[`BIT_LOL_IRQ_ENABLE];
      end
      if (wr_lane0 && (i_wb_adr == `ADDR_IRQ_MASK)) begin
        irq_mask <= i_wb_dat[1:0];
      end
      // Status bits 6 to 2 have no write path at all.
      if (bus_req && !i_wb_we) begin
        case (i_wb_adr)
          `ADDR_STATUS_CONTROL: begin
            o_wb_dat <= {24'h000000, loss_of_lock_flag, lock,
                         pll_select_status, ref_source_status,
                         clock_mode_status, 2'h0};
          end
          `ADDR_IRQ_STATUS: begin
            o_wb_dat <= {30'h0, irq_status};
          end
          `ADDR_IRQ_MASK: begin
            o_wb_dat <= {30'h0, irq_mask};
          end
          `ADDR_CONTROL: begin
            o_wb_dat <= {31'h0, loss_of_lock_irq_enable};
          end
          default: begin
            o_wb_dat <= 32'h00000000;
          end
        endcase
      end
    end
  end

endmodule

// *** logic/clock_gen_lock_status_map.vh ***
`ifndef CLOCK_GEN_LOCK_STATUS_MAP_VH
`define CLOCK_GEN_LOCK_STATUS_MAP_VH

// ----------------------------------------------------------------------
// Register byte addresses on the bus.
// ----------------------------------------------------------------------
`define ADDR_STATUS_CONTROL 4'h0
`define ADDR_IRQ_STATUS 4'h4
`define ADDR_IRQ_MASK 4'h8
`define ADDR_CONTROL 4'hc

// ----------------------------------------------------------------------
// Status and control register fields.
// ----------------------------------------------------------------------
`define BIT_LOSS_OF_LOCK 7
`define BIT_LOCK 6
`define BIT_PLL_SELECT_STATUS 5
`define BIT_REF_SOURCE_STATUS 4
`define BIT_CLOCK_MODE_HI 3
`define BIT_CLOCK_MODE_LO 2

// ----------------------------------------------------------------------
// Control register fields.
// ----------------------------------------------------------------------
`define BIT_LOL_IRQ_ENABLE 0

// ----------------------------------------------------------------------
// Interrupt status and mask fields.
// ----------------------------------------------------------------------
`define BIT_IRQ_LOSS_OF_LOCK 0
`define BIT_IRQ_LOCK_GAINED 1

// ----------------------------------------------------------------------
// Clock mode encodings and operating mode codes.
// ----------------------------------------------------------------------
`define MODE_FLL 2'h0
`define MODE_INTERNAL_REF 2'h1
`define MODE_EXTERNAL_REF 2'h2
`define MODE_PLL 2'h3
`define OP_FLL_ENG_INT 3'h0
`define OP_FLL_BYP_INT 3'h1
`define OP_PLL_BYP_EXT 3'h2
`define OP_PLL_ENG_EXT 3'h3
`define OP_LOW_POWER_INT 3'h4
`define OP_LOW_POWER_EXT 3'h5

// ----------------------------------------------------------------------
// Reset values and timing.
// ----------------------------------------------------------------------
`define RESET_STATUS 8'h00
`define SYNC_STAGES 2

`endif

// *** testbench/clock_gen_lock_status_sva.sv ***
module clock_gen_lock_status_sva (
  // Clock and reset.
  input wire i_clock,
  input wire i_rst,
  // Bus handshake.
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire [31:0] o_wb_dat,
  input wire o_wb_ack,
  // Clock generator state and lock output.
  input wire i_fll_enabled,
  input wire i_pll_enabled,
  input wire i_loop_in_tolerance,
  input wire i_pll_select,
  input wire [2:0] i_ref_divider,
  input wire [2:0] i_op_mode,
  input wire i_stop_mode,
  input wire o_lock
);
  // One clock domain, so clocking and reset are given once.
  default clocking dc @(posedge i_clock); endclocking
  default disable iff (i_rst);

  // A taken request is answered at the next edge, for one cycle only.
  AST_ACK_ONE: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
    |=> o_wb_ack) else $error("ack late");
  AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack too long");
  AST_DAT_HIGH: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0)
    else $error("upper data set");
  // The lock output trails the internal bit by one register stage.
  AST_LOCK_STOP: assert property (i_stop_mode |-> ##2 !o_lock)
    else $error("lock in stop");
  AST_LOCK_LOOPS: assert property (!i_fll_enabled && !i_pll_enabled
    |-> ##2 !o_lock) else $error("lock with loops off");
  AST_LOCK_LOWPWR: assert property ((i_op_mode == 3'h4)
    || (i_op_mode == 3'h5) |-> ##2 !o_lock) else $error("lock in low power");
  AST_LOCK_SET: assert property ($changed(i_ref_divider)
    || $changed(i_pll_select) |-> ##[1:2] !o_lock)
    else $error("lock kept after change");
  AST_LOCK_CAUSE: assert property ($rose(o_lock)
    |-> $past(i_loop_in_tolerance, 2)) else $error("lock without cause");
  AST_LOCK_DROP: assert property (!i_loop_in_tolerance
    |-> ##2 !o_lock) else $error("lock out of tolerance");
endmodule

bind clock_gen_lock_status clock_gen_lock_status_sva u_sva (.*);

// *** testbench/tb_top.sv ***
`include "clock_gen_lock_status_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  reg i_clock = 1'b0, i_rst = 1'b1;
  reg i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
  reg [3:0] i_wb_adr = 4'h0;
  reg [31:0] i_wb_dat = 32'h0;
  wire [31:0] o_wb_dat;
  wire o_wb_ack, o_irq, o_lock;
  reg fll = 1'b0, tol = 1'b0, ref_sel = 1'b1, pll_sel = 1'b0, stop = 1'b0;
  reg [1:0] clk_sel = 2'h0;
  reg [2:0] ref_divider = 3'h0, op = 3'h0;
  integer mismatches = 0, num_checks = 0, k;

  // Free-running 50 MHz clock.
  always #10 i_clock = ~i_clock;

  clock_gen_lock_status u_dut (.i_clock(i_clock), .i_rst(i_rst),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr), .i_wb_sel(4'hf), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_fll_enabled(fll),
    .i_pll_enabled(1'b0), .i_loop_in_tolerance(tol),
    .i_ref_source_select(ref_sel), .i_pll_select(pll_sel),
    .i_clock_select(clk_sel), .i_ref_divider(ref_divider),
    .i_internal_ref_adjust(8'h0), .i_vco_divider(4'h0),
    .i_op_mode(op), .i_stop_mode(stop), .o_irq(o_irq), .o_lock(o_lock));

  // ---------------------------------------------------------------
  // Bus tasks and checks.
  // ---------------------------------------------------------------
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task chk(input [7:0] g, input [7:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h want %h", $time, g, e);
    end
  endtask

  // Values read at the ack edge are the settled pre-edge values.
  task wb(input [3:0] a, input w, input [7:0] d, output [7:0] q);
    integer n;
    n = 0;
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_adr <= a;
    i_wb_dat <= {24'h0, d};
    @(posedge i_clock);
    while (o_wb_ack !== 1'b1) begin
      n++;
      if (n > 8) begin
        mismatches++;
        final_report;
      end
      @(posedge i_clock);
    end
    q = o_wb_dat[7:0];
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    @(posedge i_clock);
  endtask

  task wr(input [3:0] a, input [7:0] d);
    reg [7:0] q;
    wb(a, 1'b1, d, q);
  endtask

  task rd(input [3:0] a, input [7:0] e);
    reg [7:0] q;
    wb(a, 1'b0, 8'h0, q);
    chk(q, e);
  endtask

  task idle(input integer n);
    repeat (n) @(posedge i_clock);
  endtask

  // ---------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------
  initial begin
    idle(6);
    i_rst <= 1'b0;
    idle(1);
    rd(`ADDR_STATUS_CONTROL, 8'h10);
    rd(`ADDR_IRQ_STATUS, 8'h00);
    rd(`ADDR_CONTROL, 8'h00);
    rd(4'h2, 8'h00);
    fll <= 1'b1;
    tol <= 1'b1;
    idle(4);
    rd(`ADDR_STATUS_CONTROL, 8'h50);
    pll_sel <= 1'b1;
    ref_sel <= 1'b0;
    clk_sel <= 2'h3;
    idle(6);
    rd(`ADDR_STATUS_CONTROL, 8'h6c);
    wr(`ADDR_STATUS_CONTROL, 8'h7f);
    rd(`ADDR_STATUS_CONTROL, 8'h6c);
    // Loss of lock with the request enabled, then cleared.
    wr(`ADDR_CONTROL, 8'h01);
    wr(`ADDR_IRQ_STATUS, 8'h03);
    tol <= 1'b0;
    idle(3);
    rd(`ADDR_STATUS_CONTROL, 8'hac);
    chk({7'h0, o_irq}, 8'h01);
    rd(`ADDR_IRQ_STATUS, 8'h01);
    wr(`ADDR_STATUS_CONTROL, 8'h00);
    rd(`ADDR_STATUS_CONTROL, 8'hac);
    wr(`ADDR_STATUS_CONTROL, 8'h80);
    rd(`ADDR_STATUS_CONTROL, 8'h2c);
    chk({7'h0, o_irq}, 8'h00);
    // Loss with the enable clear, then through the event mask.
    wr(`ADDR_CONTROL, 8'h00);
    tol <= 1'b1;
    idle(3);
    tol <= 1'b0;
    idle(3);
    rd(`ADDR_STATUS_CONTROL, 8'hac);
    chk({7'h0, o_irq}, 8'h00);
    wr(`ADDR_IRQ_MASK, 8'h01);
    idle(2);
    chk({7'h0, o_irq}, 8'h01);
    wr(`ADDR_IRQ_STATUS, 8'h03);
    wr(`ADDR_STATUS_CONTROL, 8'h80);
    idle(2);
    chk({7'h0, o_irq}, 8'h00);
    // Each kill holds lock clear while it lasts.
    for (k = 0; k < 4; k++) begin
      tol <= 1'b1;
      idle(4);
      chk({7'h0, o_lock}, 8'h01);
      case (k)
        0: stop <= 1'b1;
        1: op <= 3'h4;
        2: op <= 3'h5;
        default: fll <= 1'b0;
      endcase
      idle(3);
      chk({7'h0, o_lock}, 8'h00);
      stop <= 1'b0;
      op <= 3'h0;
      fll <= 1'b1;
    end
    idle(4);
    ref_divider <= 3'h5;
    idle(3);
    chk({7'h0, o_lock}, 8'h00);
    idle(1);
    rd(`ADDR_STATUS_CONTROL, 8'h6c);
    // A flag set just before a reset is gone after it.
    tol <= 1'b0;
    idle(3);
    i_rst <= 1'b1;
    idle(2);
    i_rst <= 1'b0;
    idle(4);
    rd(`ADDR_STATUS_CONTROL, 8'h2c);
    final_report;
  end
endmodule
